// ==== inc/irq_mirror_pkg.sv ====
`default_nettype none
// =====================================================
// Shared constants and carriers of the interrupt mirror
package irq_mirror_pkg;

	// =================================================
	// Die-to-die address windows (12-bit global space)
	localparam logic [11:0] BASE_BLOCKING = 12'h200;
	localparam logic [11:0] BASE_NONBLOCKING = 12'h300;
	// Window is selected by the upper four address bits
	localparam int WINDOW_MSB = 11;
	localparam int WINDOW_LSB = 8;

	// =================================================
	// Register offsets within the window
	localparam logic [7:0] OFS_MIRROR = 8'h00;
	localparam logic [7:0] OFS_MIRROR_HI = 8'h01;
	localparam logic [7:0] OFS_VECTOR = 8'h02;

	// =================================================
	// Field positions and widths
	localparam int MIRROR_W = 16;
	localparam int VECTOR_W = 8;
	localparam int CODE_W = 6;
	localparam int VSI_BIT = 0;
	localparam int SRC_W = 13;
	localparam int VOLT_W = 5;
	localparam int PRI_W = 18;
	// Voltage flag positions, same order as voltage_status_reg
	localparam int LB_BIT = 0;
	localparam int LV_BIT = 1;
	localparam int HV_BIT = 2;
	localparam int HOT_BIT = 3;
	localparam int ROV_BIT = 4;

	// =================================================
	// Reset values
	localparam logic [15:0] MIRROR_RST = 16'h0000;
	localparam logic [7:0] VECTOR_RST = 8'h00;
	localparam logic [4:0] VOLT_RST = 5'h00;
	// Edge memory starts set: a condition at release is no edge
	localparam logic [4:0] VPREV_RST = 5'h1f;
	localparam logic [15:0] RDATA_RST = 16'h0000;

	// =================================================
	// Vector codes that the checks pin down
	localparam logic [5:0] VEC_NONE = 6'h00;
	localparam logic [5:0] VEC_LOW_VOLT = 6'h02;
	localparam logic [5:0] VEC_REG_HOT = 6'h04;
	localparam logic [5:0] VEC_LOW_BATT = 6'h06;
	localparam logic [5:0] VEC_TMR_CH0 = 6'h08;
	localparam logic [5:0] VEC_TMR_OVF = 6'h10;
	localparam logic [5:0] VEC_SER_ERR = 6'h12;
	localparam logic [5:0] VEC_CONV_DONE = 6'h18;
	localparam logic [5:0] VEC_LIN_HOT = 6'h1a;
	localparam logic [5:0] VEC_HALL_HOT = 6'h20;
	localparam logic [5:0] VEC_HIGH_VOLT = 6'h22;
	localparam logic [5:0] VEC_REG_OVERV = 6'h24;

	// =================================================
	// Requests from the source modules, MSB first
	typedef struct packed {
		logic hall_supply_hot_req;
		logic low_side_hot_req;
		logic high_side_hot_req;
		logic lin_driver_hot_req;
		logic converter_sequence_done_req;
		logic serial_rx_req;
		logic serial_tx_req;
		logic serial_err_req;
		logic timer_overflow_req;
		logic timer_chan_three_req;
		logic timer_chan_two_req;
		logic timer_chan_one_req;
		logic timer_chan_zero_req;
	} src_req_t;

	// Raw voltage conditions, MSB first
	typedef struct packed {
		logic regulator_overvoltage_req;
		logic regulator_hot_req;
		logic high_voltage_req;
		logic low_voltage_req;
		logic low_battery_req;
	} volt_cond_t;

	// Register read answer
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} rd_resp_t;

	// Whole state of the top module
	typedef struct packed {
		logic [15:0] mirror;
		logic [7:0] vector;
		logic [4:0] vflag;
		logic [4:0] vprev;
		logic irq;
		rd_resp_t rd;
	} state_t;

endpackage
`default_nettype wire

// ==== hw/first_pending_code.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Priority encoder: bit 0 of the request vector ranks
// highest; the code is the rank number shifted by one
module first_pending_code (
	input wire logic [17:0] pri_req_in, // Requests, bit 0 first
	input wire logic wake_in, // Stop-mode wake-up pending
	output logic [5:0] code_out // Pre-shifted vector code
);
	import irq_mirror_pkg::*;

	// =================================================
	// Scan from lowest rank upward so the best one wins
	always_comb begin
		code_out = VEC_NONE;
		for (int i = PRI_W - 1; i >= 0; i--) begin
			if (pri_req_in[i]) begin
				// Even codes index a table of 2-byte entries
				code_out = 6'((i + 1) << 1);
			end
		end
		// Wake-up outranks all and shares the idle code
		if (wake_in) begin
			code_out = VEC_NONE;
		end
	end

endmodule
`default_nettype wire

// ==== hw/irq_source_mirror_vector.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Any voltage flag sets combined voltage bit
// - Mirror shows every pending source
// - Mirror read acknowledges nothing
// - Fixed mirror layout, bits 15:14 zero
// - Vector gives highest-priority pending code
// - Code is source number shifted left
// - Vector read acknowledges nothing
// - Six-bit code, zero when idle
// - Stop wake-up ranks first, code zero
// - Low voltage, regulator hot, low battery
// - Timer channels then overflow follow
// - Serial error, transmit, receive, converter next
// - Four overtemperature sources follow
// - High voltage, then regulator overvoltage last
// - Decode at blocking and non-blocking bases
// - Interrupt high while pending, normal mode
// - Status request rearms after condition clears
module irq_source_mirror_vector (
	input wire logic clk_in, // 25 MHz clock
	input wire logic rst_in, // Sync reset, high
	input wire irq_mirror_pkg::src_req_t src_req_in, // Module requests
	input wire irq_mirror_pkg::volt_cond_t volt_cond_in, // Raw conditions
	input wire logic volt_ack_in, // Voltage status read pulse
	input wire logic wake_pending_in, // Stop wake-up pending
	input wire logic normal_mode_in, // Device in normal mode
	input wire logic rd_in, // Register read strobe
	input wire logic [11:0] rd_addr_in, // Global read address
	output logic [15:0] source_mirror_reg_out, // Mirror register
	output logic [7:0] vector_code_reg_out, // Vector register
	output logic die_link_irq_out, // Interrupt line
	output logic rd_valid_out, // Read answer valid
	output logic [15:0] rd_data_out // Read answer data
);
	import irq_mirror_pkg::*;

	// =================================================
	// State and its next value
	state_t st_q; // Registered state
	state_t st_d; // Next state
	logic [4:0] vcond; // Conditions as a flat vector
	logic [4:0] vrise; // New condition edges
	logic [17:0] pri_req; // Requests in rank order
	logic [5:0] code; // Encoder result
	logic [15:0] mirror_now; // Mirror from current flags
	logic [7:0] rd_ofs; // Offset inside window
	logic rd_hit; // Read falls in a window

	// =================================================
	// Address window match, used for both bases
	function automatic logic in_window(
		input logic [11:0] addr,
		input logic [11:0] base
	);
		in_window = addr[WINDOW_MSB:WINDOW_LSB] ==
			base[WINDOW_MSB:WINDOW_LSB];
	endfunction

	// =================================================
	// Priority encoder
	first_pending_code u_enc (
		.pri_req_in(pri_req),
		.wake_in(wake_pending_in),
		.code_out(code)
	);

	// =================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		vcond = volt_cond_in;
		// Edge only when condition was absent last cycle
		vrise = vcond & ~st_q.vprev;
		st_d.vprev = vcond;
		// Ack clears, but a fresh edge in the same cycle wins
		if (volt_ack_in) begin
			st_d.vflag = VOLT_RST;
		end
		st_d.vflag = st_d.vflag | vrise;
		// Combined voltage bit is the OR of five flags
		mirror_now = MIRROR_RST;
		mirror_now[VSI_BIT] = |st_q.vflag;
		// Module requests shown as they stand, top bits zero
		mirror_now[SRC_W:1] = src_req_in;
		st_d.mirror = mirror_now;
		// Voltage flags are ranked one by one
		// Eighteen ranks: three voltage flags lead, thirteen
		// module requests follow, two voltage flags close
		pri_req = {st_q.vflag[ROV_BIT],
			st_q.vflag[HV_BIT],
			src_req_in,
			st_q.vflag[LB_BIT],
			st_q.vflag[HOT_BIT],
			st_q.vflag[LV_BIT]};
		// Code sits in bits 5:0, upper bits read zero
		st_d.vector = {2'b00, code};
		// Line only in normal mode, any mirror bit raises it
		st_d.irq = normal_mode_in && (|mirror_now);
		// Read answer; a read never touches the flags
		rd_hit = in_window(rd_addr_in, BASE_BLOCKING) ||
			in_window(rd_addr_in, BASE_NONBLOCKING);
		rd_ofs = rd_addr_in[7:0];
		st_d.rd.valid = rd_in;
		st_d.rd.data = RDATA_RST;
		if (rd_in && rd_hit) begin
			// Plain decode; reads have no side effects
			if (rd_ofs == OFS_MIRROR) begin
				st_d.rd.data = st_q.mirror;
			end else if (rd_ofs == OFS_MIRROR_HI) begin
				// Byte access to the upper half
				st_d.rd.data = {8'h00, st_q.mirror[15:8]};
			end else if (rd_ofs == OFS_VECTOR) begin
				st_d.rd.data = {8'h00, st_q.vector};
			end else begin
				// Unmapped offsets read zero
				st_d.rd.data = RDATA_RST;
			end
		end
	end

	// =================================================
	// State register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q.mirror <= MIRROR_RST;
			st_q.vector <= VECTOR_RST;
			st_q.vflag <= VOLT_RST;
			// Condition present at release is not an edge:
			// the flag waits for it to clear and return
			st_q.vprev <= VPREV_RST;
			st_q.irq <= 1'b0;
			st_q.rd.valid <= 1'b0;
			st_q.rd.data <= RDATA_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// =================================================
	// Outputs straight from the state register
	// Costs a cycle of latency, but no output can glitch
	// while the requests settle
	assign source_mirror_reg_out = st_q.mirror;
	assign vector_code_reg_out = st_q.vector;
	assign die_link_irq_out = st_q.irq;
	assign rd_valid_out = st_q.rd.valid;
	assign rd_data_out = st_q.rd.data;

	// =================================================
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// New voltage edge shows in the combined bit two later
	a_vsi_combine:
	assert property ((|(vcond & ~st_q.vprev)) && !volt_ack_in
		|-> ##2 st_q.mirror[VSI_BIT])
	else $error("combined voltage bit not set");

	// Module requests mirrored one cycle later
	a_mirror_bits:
	assert property (1'b1 |=> st_q.mirror[SRC_W:1] ==
		$past(src_req_in))
	else $error("mirror does not follow requests");

	// Top bits never set
	a_mirror_top:
	assert property (st_q.mirror[15:14] == 2'b00)
	else $error("mirror bits 15:14 not zero");

	// A read without ack keeps every flag
	a_read_keeps:
	assert property (rd_in && !volt_ack_in |=>
		($past(st_q.vflag) & ~st_q.vflag) == 5'h00)
	else $error("read cleared a voltage flag");

	// Reading the vector returns the held code unchanged
	a_vec_read:
	assert property (rd_in && rd_addr_in ==
		(BASE_NONBLOCKING | 12'(OFS_VECTOR))
		|=> rd_valid_out && rd_data_out[7:0] ==
		$past(st_q.vector))
	else $error("vector read data wrong");

	// Codes are always even with zero upper bits
	a_vec_even:
	assert property (st_q.vector[0] == 1'b0 &&
		st_q.vector[7:6] == 2'b00)
	else $error("vector code odd or upper bits set");

	// Nothing pending gives code zero
	a_vec_idle:
	assert property (pri_req == 18'h00000 |=>
		st_q.vector == VECTOR_RST)
	else $error("idle vector not zero");

	// Wake-up forces code zero over any request
	a_wake_zero:
	assert property (wake_pending_in |=>
		st_q.vector[5:0] == VEC_NONE)
	else $error("wake-up code not zero");

	// Low voltage beats everything but wake-up
	a_lvi_code:
	assert property (!wake_pending_in && st_q.vflag[LV_BIT]
		|=> st_q.vector[5:0] == VEC_LOW_VOLT)
	else $error("low voltage code wrong");

	// Timer channel 0 alone
	a_tmr_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00008 |=>
		st_q.vector[5:0] == VEC_TMR_CH0)
	else $error("timer channel code wrong");

	// Hall supply alone
	a_hall_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h08000 |=>
		st_q.vector[5:0] == VEC_HALL_HOT)
	else $error("hall supply code wrong");

	// Regulator overvoltage alone ranks last
	a_rov_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h20000 |=>
		st_q.vector[5:0] == VEC_REG_OVERV)
	else $error("overvoltage code wrong");

	// Mirror read at the blocking base
	a_blk_decode:
	assert property (rd_in && rd_addr_in == BASE_BLOCKING
		|=> rd_valid_out && rd_data_out == $past(st_q.mirror))
	else $error("blocking mirror read wrong");

	// No line outside normal mode
	a_irq_mode:
	assert property (!normal_mode_in |=> !die_link_irq_out)
	else $error("interrupt outside normal mode");

	// Line follows any mirrored request
	a_irq_or:
	assert property (normal_mode_in && (|mirror_now)
		|=> die_link_irq_out)
	else $error("interrupt not raised");

	// Ack with condition still present does not rearm
	a_rearm_wait:
	assert property (volt_ack_in && st_q.vprev[LV_BIT] &&
		vcond[LV_BIT] |=> !st_q.vflag[LV_BIT])
	else $error("flag rearmed without new edge");

	// =================================================
	// Further ranks, byte access, the ack path and idle outputs

	// Regulator hot alone ranks second
	a_hot_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00002 |=>
		st_q.vector[5:0] == VEC_REG_HOT)
	else $error("regulator hot code wrong");

	// Low battery alone ranks third
	a_lbat_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00004 |=>
		st_q.vector[5:0] == VEC_LOW_BATT)
	else $error("low battery code wrong");

	// Timer overflow alone
	a_ovf_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00080 |=>
		st_q.vector[5:0] == VEC_TMR_OVF)
	else $error("timer overflow code wrong");

	// Serial error alone
	a_serr_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00100 |=>
		st_q.vector[5:0] == VEC_SER_ERR)
	else $error("serial error code wrong");

	// Converter sequence done alone
	a_conv_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h00800 |=>
		st_q.vector[5:0] == VEC_CONV_DONE)
	else $error("converter code wrong");

	// Line driver overtemperature alone
	a_lin_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h01000 |=>
		st_q.vector[5:0] == VEC_LIN_HOT)
	else $error("line driver code wrong");

	// High voltage alone
	a_hv_code:
	assert property (!wake_pending_in &&
		pri_req == 18'h10000 |=>
		st_q.vector[5:0] == VEC_HIGH_VOLT)
	else $error("high voltage code wrong");

	// Regulator hot beats every module request
	a_vec_rank:
	assert property (!wake_pending_in &&
		st_q.vflag[HOT_BIT] && !st_q.vflag[LV_BIT]
		|=> st_q.vector[5:0] == VEC_REG_HOT)
	else $error("priority order wrong");

	// Byte read of the upper mirror half
	a_byte_hi:
	assert property (rd_in && rd_addr_in ==
		(BASE_BLOCKING | 12'(OFS_MIRROR_HI))
		|=> rd_valid_out && rd_data_out ==
		{8'h00, $past(st_q.mirror[15:8])})
	else $error("upper byte read wrong");

	// Ack without a fresh edge empties all flags
	a_ack_clear:
	assert property (volt_ack_in && !(|(vcond & ~st_q.vprev))
		|=> st_q.vflag == VOLT_RST)
	else $error("ack left a voltage flag set");

	// Fresh edge in the ack cycle keeps its flag
	a_set_wins:
	assert property (volt_ack_in && vcond[LB_BIT] &&
		!st_q.vprev[LB_BIT] |=> st_q.vflag[LB_BIT])
	else $error("ack swallowed a fresh edge");

	// No flag left means the combined bit is clear
	a_vsi_empty:
	assert property (!(|st_q.vflag) |=> !st_q.mirror[VSI_BIT])
	else $error("combined voltage bit stuck");

	// Line drops once nothing is mirrored
	a_irq_idle:
	assert property (!(|mirror_now) |=> !die_link_irq_out)
	else $error("interrupt without request");

endmodule
`default_nettype wire

// ==== verification/die_link_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Host side of the register read port
module die_link_host (
	input wire logic clk_in, // Clock
	input wire logic rd_valid_in, // Answer valid
	input wire logic [15:0] rd_data_in, // Answer data
	output logic rd_out, // Read strobe
	output logic [11:0] rd_addr_out, // Read address
	output logic volt_ack_out // Voltage status read pulse
);
	// Idle levels before the first access
	initial begin
		rd_out = 1'b0;
		rd_addr_out = 12'hfff;
		volt_ack_out = 1'b0;
	end

	// One read; a released address is inverted, not held
	task automatic read(input logic [11:0] a, output logic [15:0] d,
		output bit ok);
		ok = 1'b0;
		d = 16'h0000;
		@(negedge clk_in);
		rd_out = 1'b1;
		rd_addr_out = a;
		@(negedge clk_in);
		rd_out = 1'b0;
		rd_addr_out = ~a;
		// Bounded wait for the one-cycle answer
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				d = rd_data_in;
				ok = 1'b1;
			end else begin
				@(negedge clk_in);
			end
		end
	endtask

	// Separate access that serves the voltage flags
	task automatic ack_volt();
		@(negedge clk_in);
		volt_ack_out = 1'b1;
		@(negedge clk_in);
		volt_ack_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verification/irq_source_mirror_vector_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Register-level test of the interrupt mirror
module irq_source_mirror_vector_test;
	import irq_mirror_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	src_req_t src_req;
	volt_cond_t volt_cond;
	logic wake, normal_mode, rd, volt_ack, irq, rd_valid;
	logic [11:0] rd_addr;
	logic [15:0] mirror, rd_data;
	logic [7:0] vector;
	int err_total = 0;
	int total_checks = 0;
	// Vector code of each voltage flag, in flag bit order
	logic [5:0] volt_code [5] = '{6'h06, 6'h02, 6'h22, 6'h04, 6'h24};

	// 25 MHz clock
	always #20 clk_in = ~clk_in;

	irq_source_mirror_vector DUT (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.src_req_in(src_req),
		.volt_cond_in(volt_cond),
		.volt_ack_in(volt_ack),
		.wake_pending_in(wake),
		.normal_mode_in(normal_mode),
		.rd_in(rd),
		.rd_addr_in(rd_addr),
		.source_mirror_reg_out(mirror),
		.vector_code_reg_out(vector),
		.die_link_irq_out(irq),
		.rd_valid_out(rd_valid),
		.rd_data_out(rd_data)
	);

	die_link_host host (
		.clk_in(clk_in),
		.rd_valid_in(rd_valid),
		.rd_data_in(rd_data),
		.rd_out(rd),
		.rd_addr_out(rd_addr),
		.volt_ack_out(volt_ack)
	);

	// =====================================
	// Checking and reporting
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Read a register; a missing answer ends the run
	task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
		logic [15:0] d;
		bit ok;
		host.read(a, d, ok);
		if (!ok) begin
			err_total++;
			final_report();
		end
		chk(d, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// =====================================
	// Scenarios
	initial begin
		src_req = '0;
		volt_cond = '0;
		wake = 1'b0;
		normal_mode = 1'b1;
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		// Idle after reset
		rd_chk(12'h200, 16'h0000);
		rd_chk(12'h202, 16'h0000);
		chk(16'(irq), 16'h0000);
		// Each module request alone, mirror read in both windows
		for (int i = 0; i < 13; i++) begin
			src_req = src_req_t'(13'h1 << i);
			cyc(1);
			rd_chk(12'h200, 16'h2 << i);
			rd_chk(12'h300, 16'h2 << i);
			rd_chk(12'h302, 16'((i + 4) * 2));
			chk(16'(irq), 16'h0001);
			chk(mirror, 16'h2 << i);
			chk(16'(vector), 16'((i + 4) * 2));
		end
		src_req = '0;
		// Each voltage flag: set, acknowledge, hold, rearm
		for (int i = 0; i < 5; i++) begin
			volt_cond = volt_cond_t'(5'h1 << i);
			cyc(3);
			rd_chk(12'h200, 16'h0001);
			rd_chk(12'h202, 16'(volt_code[i]));
			rd_chk(12'h202, 16'(volt_code[i]));
			chk(mirror, 16'h0001);
			chk(16'(vector), 16'(volt_code[i]));
			host.ack_volt();
			cyc(3);
			rd_chk(12'h200, 16'h0000);
			chk(16'(irq), 16'h0000);
			volt_cond = '0;
			cyc(1);
			volt_cond = volt_cond_t'(5'h1 << i);
			cyc(3);
			rd_chk(12'h200, 16'h0001);
			host.ack_volt();
			volt_cond = '0;
			cyc(3);
		end
		// Everything pending: layout, byte alias, priority, wake-up
		src_req = '1;
		volt_cond = '1;
		cyc(3);
		rd_chk(12'h200, 16'h3fff);
		rd_chk(12'h201, 16'h003f);
		rd_chk(12'h202, 16'h0002);
		wake = 1'b1;
		cyc(2);
		rd_chk(12'h302, 16'h0000);
		wake = 1'b0;
		normal_mode = 1'b0;
		cyc(2);
		chk(16'(irq), 16'h0000);
		rd_chk(12'h100, 16'h0000);
		rd_chk(12'h2ff, 16'h0000);
		normal_mode = 1'b1;
		// Voltage flags served, module requests still pending
		host.ack_volt();
		cyc(3);
		rd_chk(12'h202, 16'h0008);
		rd_chk(12'h200, 16'h3ffe);
		chk(16'(irq), 16'h0001);
		// Reset mid-run: a condition present at release is no edge
		rst_in = 1'b1;
		cyc(2);
		chk(mirror, 16'h0000);
		chk(16'(irq), 16'h0000);
		rst_in = 1'b0;
		cyc(2);
		rd_chk(12'h200, 16'h3ffe);
		rd_chk(12'h202, 16'h0008);
		// Fresh edge in the ack cycle: the set wins
		volt_cond = '0;
		cyc(1);
		fork
			host.ack_volt();
			begin
				cyc(1);
				volt_cond = volt_cond_t'(5'h01);
			end
		join
		cyc(3);
		rd_chk(12'h202, 16'h0006);
		final_report();
	end
endmodule
`default_nettype wire
